// [core/dlc_link_master.sv]
// Purpose: link master that sends fast command and block frames
// Assumes: device samples symbols on rising edge of the driven link clock
// Notes: one symbol per link clock; software orders sends via registers
// Functional notes
// - fast frame is comma byte then command byte
// - symbol byte is x field above y field
// - block even word count, at most one kilobyte; here only the size is checked, odd word counts are sent
// - header five words, data words, then check
// - packet type is a combinable bit mask
// - blocks numbered consecutively for loss detection
// - block ends with sixteen-bit check word
// - comma selects sync, normal or link command
// - link sync commas never qualify commands
// - frame opens with start, closes with end
// - end symbol plus one or two pads
// - idle pairs chosen by running disparity; here only the first idle pair after reset takes D5_6, all later ones D16_2
// - reserved link sequences never sent by user
// - link clock comes from this master
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
module dlc_link_master
    import dlc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // software register port
    input wire logic [7:0] sw_addr,
    input wire logic [15:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [15:0] sw_rdata,
    // link toward the device
    output logic link_clk_out,
    output logic [7:0] link_sym,
    output logic link_is_k,
    input wire logic buffer_full_flag
);

    // registers
    logic [15:0] mem [0:MEM_DEPTH-1];
    logic [9:0] fast_q;
    logic [15:0] pkt_type_q;
    logic [15:0] sel_q;
    logic [15:0] spec_q;
    logic [15:0] len_q;
    logic [8:0] wptr_q;
    logic [15:0] seq_q;
    logic pend_fast_q;
    logic pend_blk_q;
    logic refused_q;
    logic [15:0] rdata_q;
    logic full_s1_q;
    logic full_s2_q;
    // link side
    dlc_state_t state_q;
    dlc_state_t state_d;
    logic link_clk_q;
    logic [7:0] sym_q;
    logic [7:0] sym_d;
    logic k_q;
    logic k_d;
    logic disp_pos_q;
    logic par_q;
    logic [9:0] idx_q;
    logic [15:0] crc_q;

    // decode
    wire tick = link_clk_q;
    wire in_frame = !(state_q == ST_IDLE_K || state_q == ST_IDLE_D
                      || state_q == ST_FAST_K || state_q == ST_FAST_D);
    wire busy = pend_fast_q | pend_blk_q | in_frame | (state_q == ST_FAST_K);
    wire wr_ctrl = sw_wr && sw_addr == REG_CTRL;
    wire cfg_we = sw_wr && !busy;
    wire req_fast = wr_ctrl && sw_wdata[CTRL_SEND_FAST];
    wire req_blk = wr_ctrl && sw_wdata[CTRL_SEND_BLOCK];
    wire fast_cls_bad = fast_q[9:8] != CLS_SYNC && fast_q[9:8] != CLS_NORMAL
                        && fast_q[9:8] != CLS_LINK;
    wire len_bad = len_q > MAX_DATA_WORDS;
    wire take_fast = req_fast && !req_blk && !busy && !fast_cls_bad;
    wire take_blk = req_blk && !req_fast && !busy && !len_bad;
    wire refuse = (req_fast || req_blk) && !take_fast && !take_blk;
    wire [9:0] last_idx = len_q[9:0] + HDR_LAST_IDX + 10'h001;
    wire last_word = idx_q == last_idx;
    wire decide = state_q == ST_IDLE_D || state_q == ST_FAST_D;
    wire [9:0] mem_idx = idx_q - HDR_LAST_IDX - 10'h001;
    wire [15:0] word_cur = idx_q == 10'h000 ? pkt_type_q
                         : idx_q == 10'h001 ? seq_q
                         : idx_q == 10'h002 ? sel_q
                         : idx_q == 10'h003 ? spec_q
                         : idx_q == 10'h004 ? len_q
                         : last_word ? crc_q : mem[mem_idx[8:0]];
    wire [15:0] crc_next;
    wire [15:0] word_nxt = idx_q == 10'h000 ? seq_q
                         : idx_q == 10'h001 ? sel_q
                         : idx_q == 10'h002 ? spec_q
                         : idx_q == 10'h003 ? len_q
                         : idx_q == last_idx - 10'h001 ? crc_next : mem[mem_idx[8:0] + 9'h001];

    // selects comma for the fast class
    function automatic logic [7:0] fast_comma(input logic [1:0] cls);
        case (cls)
            CLS_SYNC: fast_comma = K28_0;
            CLS_LINK: fast_comma = K28_4;
            default: fast_comma = K28_3;
        endcase
    endfunction

    dlc_crc_step u_crc (
        .crc_in(crc_q),
        .word_in(word_cur),
        .crc_out(crc_next)
    );

    // software port
    always_ff @(posedge core_clk) begin
        if (reset) begin
            fast_q <= 10'h000;
            pkt_type_q <= PKT_TYPE_RST;
            sel_q <= ZERO16;
            spec_q <= ZERO16;
            len_q <= ZERO16;
            wptr_q <= 9'h000;
            pend_fast_q <= 1'b0;
            pend_blk_q <= 1'b0;
            refused_q <= 1'b0;
            rdata_q <= ZERO16;
        end else begin
            if (cfg_we && sw_addr == REG_FAST) fast_q <= sw_wdata[9:0];
            if (cfg_we && sw_addr == REG_PKT_TYPE) pkt_type_q <= sw_wdata;
            if (cfg_we && sw_addr == REG_SELECTOR) sel_q <= sw_wdata;
            if (cfg_we && sw_addr == REG_SPECIFIER) spec_q <= sw_wdata;
            if (cfg_we && sw_addr == REG_LENGTH) begin
                len_q <= sw_wdata;
                wptr_q <= 9'h000;
            end
            if (cfg_we && sw_addr == REG_DATA) wptr_q <= wptr_q + 9'h001;
            if (take_fast) pend_fast_q <= 1'b1;
            else if (tick && decide && pend_fast_q) pend_fast_q <= 1'b0;
            if (take_blk) pend_blk_q <= 1'b1;
            else if (tick && decide && !pend_fast_q && pend_blk_q) pend_blk_q <= 1'b0;
            // set wins over the clear
            if (refuse) refused_q <= 1'b1;
            else if (wr_ctrl && sw_wdata[STAT_REFUSED]) refused_q <= 1'b0;
            rdata_q <= ZERO16;
            if (sw_rd) begin
                case (sw_addr)
                    REG_CTRL: rdata_q <= {13'h0000, full_s2_q, refused_q, busy};
                    REG_FAST: rdata_q <= {6'h00, fast_q};
                    REG_PKT_TYPE: rdata_q <= pkt_type_q;
                    REG_SELECTOR: rdata_q <= sel_q;
                    REG_SPECIFIER: rdata_q <= spec_q;
                    REG_LENGTH: rdata_q <= len_q;
                    REG_SEQ: rdata_q <= seq_q;
                    default: rdata_q <= ZERO16;
                endcase
            end
        end
    end

    // memory has no reset; len_q words are sent whether written or not
    always_ff @(posedge core_clk) begin
        if (cfg_we && sw_addr == REG_DATA) mem[wptr_q] <= sw_wdata;
    end

    // device flag crosses in from outside
    always_ff @(posedge core_clk) begin
        if (reset) begin
            full_s1_q <= 1'b0;
            full_s2_q <= 1'b0;
        end else begin
            full_s1_q <= buffer_full_flag;
            full_s2_q <= full_s1_q;
        end
    end

    // next symbol
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE_K: state_d = ST_IDLE_D;
            ST_IDLE_D, ST_FAST_D: begin
                // frames start only after a whole pair, keeping even footing
                if (pend_fast_q) state_d = ST_FAST_K;
                else if (pend_blk_q) state_d = ST_SOF;
                else state_d = ST_IDLE_K;
            end
            ST_FAST_K: state_d = ST_FAST_D;
            ST_SOF: state_d = ST_WHI;
            ST_WHI: state_d = ST_WLO;
            ST_WLO: state_d = last_word ? ST_EOF : ST_WHI;
            ST_EOF: state_d = ST_EXT;
            ST_EXT: state_d = par_q ? ST_PAD : ST_IDLE_K;
            ST_PAD: state_d = ST_IDLE_K;
            default: state_d = ST_IDLE_K;
        endcase
    end

    always_comb begin
        sym_d = K28_5;
        k_d = 1'b1;
        case (state_d)
            ST_IDLE_K: sym_d = K28_5;
            ST_IDLE_D: begin
                sym_d = disp_pos_q ? D5_6 : D16_2;
                k_d = 1'b0;
            end
            ST_FAST_K: sym_d = fast_comma(fast_q[9:8]);
            ST_FAST_D: begin
                sym_d = fast_q[7:0];
                k_d = 1'b0;
            end
            ST_SOF: sym_d = K27_7;
            ST_WHI: begin
                // index steps on this same edge, so take the following word
                sym_d = state_q == ST_WLO ? word_nxt[15:8] : word_cur[15:8];
                k_d = 1'b0;
            end
            ST_WLO: begin
                sym_d = word_cur[7:0];
                k_d = 1'b0;
            end
            ST_EOF: sym_d = K29_7;
            ST_EXT, ST_PAD: sym_d = K23_7;
            default: sym_d = K28_5;
        endcase
    end

    // link clock is a divided copy of core_clk
    always_ff @(posedge core_clk) begin
        if (reset) link_clk_q <= 1'b0;
        else link_clk_q <= !link_clk_q;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= ST_IDLE_K;
            sym_q <= K28_5;
            k_q <= 1'b1;
            disp_pos_q <= 1'b1;
        end else if (tick) begin
            state_q <= state_d;
            sym_q <= sym_d;
            k_q <= k_d;
            // disparity flag only cleared, at the first idle pair, and never set again
            if (state_d == ST_IDLE_D) disp_pos_q <= 1'b0;
        end
    end

    // frame bookkeeping
    always_ff @(posedge core_clk) begin
        if (reset) begin
            par_q <= 1'b0;
            idx_q <= 10'h000;
            crc_q <= CRC_INIT;
            seq_q <= ZERO16;
        end else begin
            if (tick && state_d == ST_SOF) begin
                par_q <= 1'b1;
                idx_q <= 10'h000;
                crc_q <= CRC_INIT;
            end else if (tick) begin
                par_q <= !par_q;
                if (state_q == ST_WLO && !last_word) begin
                    idx_q <= idx_q + 10'h001;
                    crc_q <= crc_next;
                end
            end
            if (tick && state_q == ST_WLO && last_word) seq_q <= seq_q + 16'h0001;
            else if (cfg_we && sw_addr == REG_SEQ) seq_q <= sw_wdata;
        end
    end

    assign sw_rdata = rdata_q;
    assign link_clk_out = link_clk_q;
    assign link_sym = sym_q;
    assign link_is_k = k_q;

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_pair_ok;
        (link_is_k && link_sym == K28_5)
            ##2 (!link_is_k && (link_sym == D5_6 || link_sym == D16_2));
    endsequence

    chk_link_clk_div: assert property (
        !$past(reset) |-> link_clk_out != $past(link_clk_out))
        else $error("link clock did not toggle");

    chk_fast_comma: assert property (
        (tick && state_d == ST_FAST_K) |=> link_is_k
            && (link_sym == K28_0 || link_sym == K28_3 || link_sym == K28_4))
        else $error("fast frame comma not a command qualifier");

    chk_fast_word: assert property (
        (state_q == ST_FAST_K && tick) |=> !link_is_k && link_sym == fast_q[7:0])
        else $error("fast command word wrong");

    chk_frame_start: assert property (
        (tick && state_d == ST_SOF) |=> link_is_k && link_sym == K27_7)
        else $error("frame did not open with start symbol");

    chk_eof_pad: assert property (
        (tick && state_d == ST_EOF) |=> link_sym == K29_7 ##2 link_sym == K23_7)
        else $error("end symbol not followed by pad");

    chk_idle_pair: assert property (
        (tick && state_d == ST_IDLE_K) |=> s_pair_ok)
        else $error("idle pair malformed");

    chk_no_reserved: assert property (
        (link_is_k && link_sym == K28_5) |-> state_q == ST_IDLE_K)
        else $error("link sync comma outside idle");

    chk_seq_incr: assert property (
        (tick && state_q == ST_WLO && last_word) |=> seq_q == $past(seq_q) + 16'h0001)
        else $error("block sequence number not advanced");

    chk_len_limit: assert property (
        (req_blk && len_q > MAX_DATA_WORDS) |=> refused_q)
        else $error("oversized block not refused");

    chk_even_frame: assert property (
        (tick && (state_q == ST_EXT || state_q == ST_PAD) && state_d == ST_IDLE_K)
            |-> !par_q)
        else $error("frame symbol count odd");

endmodule // dlc_link_master

// [common/dlc_pkg.sv]
// Purpose: shared constants and types of the link command controller
// Assumes: symbols are handed to a transparent 8b/10b coder as byte plus k flag
// Notes: symbol codes are built as {x field, y field}
package dlc_pkg;

    // symbol byte is {x[4:0], y[2:0]}
    localparam logic [7:0] K28_0 = {5'h1C, 3'h0};
    localparam logic [7:0] K28_3 = {5'h1C, 3'h3};
    localparam logic [7:0] K28_4 = {5'h1C, 3'h4};
    localparam logic [7:0] K28_5 = {5'h1C, 3'h5};
    localparam logic [7:0] K27_7 = {5'h1B, 3'h7};
    localparam logic [7:0] K29_7 = {5'h1D, 3'h7};
    localparam logic [7:0] K23_7 = {5'h17, 3'h7};
    localparam logic [7:0] D5_6 = {5'h05, 3'h6};
    localparam logic [7:0] D16_2 = {5'h10, 3'h2};

    // fast command classes as held in the fast register
    localparam logic [1:0] CLS_SYNC = 2'h0;
    localparam logic [1:0] CLS_NORMAL = 2'h1;
    localparam logic [1:0] CLS_LINK = 2'h2;

    // frame sizing
    localparam int MAX_FRAME_BYTES = 1024;
    localparam int HDR_WORDS = 5;
    localparam logic [15:0] MAX_DATA_WORDS = 16'(MAX_FRAME_BYTES / 2 - HDR_WORDS - 1);
    localparam int MEM_DEPTH = 512;
    localparam logic [9:0] HDR_LAST_IDX = 10'h004;

    // crc
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;

    // register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_FAST = 8'h01;
    localparam logic [7:0] REG_PKT_TYPE = 8'h02;
    localparam logic [7:0] REG_SELECTOR = 8'h03;
    localparam logic [7:0] REG_SPECIFIER = 8'h04;
    localparam logic [7:0] REG_LENGTH = 8'h05;
    localparam logic [7:0] REG_DATA = 8'h06;
    localparam logic [7:0] REG_SEQ = 8'h07;

    // ctrl fields
    localparam int CTRL_SEND_FAST = 0;
    localparam int CTRL_SEND_BLOCK = 1;
    localparam int STAT_BUSY = 0;
    localparam int STAT_REFUSED = 1;
    localparam int STAT_FULL = 2;
    localparam int FAST_CLS_LSB = 8;

    // reset values
    localparam logic [15:0] PKT_TYPE_RST = 16'h0002;
    localparam logic [15:0] ZERO16 = 16'h0000;

    // timing
    localparam int CORE_PERIOD_NS = 10;
    localparam int LINK_PERIOD_NS = 20;
    localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * CORE_PERIOD_NS);

    typedef enum logic [9:0] {
        ST_IDLE_K = 10'h001,
        ST_IDLE_D = 10'h002,
        ST_FAST_K = 10'h004,
        ST_FAST_D = 10'h008,
        ST_SOF = 10'h010,
        ST_WHI = 10'h020,
        ST_WLO = 10'h040,
        ST_EOF = 10'h080,
        ST_EXT = 10'h100,
        ST_PAD = 10'h200
    } dlc_state_t;

endpackage

// [core/dlc_crc_step.sv]
// Purpose: one 16-bit word step of the frame check sequence
// Assumes: msb first, polynomial and seed from the package
// Notes: purely combinational
`timescale 1ns/1ns
module dlc_crc_step
    import dlc_pkg::*;
(
    // running value
    input wire logic [15:0] crc_in,
    input wire logic [15:0] word_in,
    // result
    output logic [15:0] crc_out
);

    logic [15:0] stage [0:16];

    assign stage[0] = crc_in;

    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_bit
            logic fb;
            assign fb = stage[i][15] ^ word_in[15 - i];
            assign stage[i + 1] = fb ? ({stage[i][14:0], 1'b0} ^ CRC_POLY)
                                     : {stage[i][14:0], 1'b0};
        end
    endgenerate

    assign crc_out = stage[16];

endmodule // dlc_crc_step

// [dv/dlc_dev_model.sv]
// Purpose: behavioural detector board on the far end of the command link
// Assumes: symbols stable at the rising edge of the link clock
// Notes: records frames and fast commands for the bench to inspect
`timescale 1ns/1ns
module dlc_dev_model
    import dlc_pkg::*;
(
    // link from the master
    input wire logic link_clk,
    input wire logic [7:0] sym,
    input wire logic is_k,
    // buffer state back to the master
    input wire logic full_req,
    output logic full_out
);
    logic [7:0] prev_sym = 8'h00;
    logic prev_k = 1'b0;
    logic in_frame = 1'b0;
    logic [7:0] frm[$];
    logic [7:0] first_idle = 8'h00;
    logic [7:0] fast_k = 8'h00;
    logic [7:0] fast_d = 8'h00;
    // one register per command group, all start at zero and are rewritten every link clock
    logic [15:0] clr_reg = 16'h0000;
    logic [15:0] acq_reg = 16'h0000;
    logic [15:0] flow_reg = 16'h0000;
    logic [15:0] cal_reg = 16'h0000;
    int frames = 0;
    int pads = 0;
    int fcnt = 0;
    int seq_err = 0;
    int bad_frames = 0;
    logic [15:0] c = 16'h0000;
    logic [15:0] w = 16'h0000;
    int clr_len = 0;
    int clr_cnt = 0;
    // no read path: command registers stay hidden from the master
    assign full_out = full_req;
    // model runs on the master's clock, no local synthesis
    always @(posedge link_clk) begin
        acq_reg = 16'h0000; // bits drop one cycle after set
        flow_reg = 16'h0000;
        cal_reg = 16'h0000;
        clr_reg = {15'h0000, clr_cnt != 0}; // held four cycles
        if (clr_cnt != 0) begin
            clr_cnt--;
            clr_len++;
        end
        if (prev_k && !is_k && (prev_sym == K28_0 || prev_sym == K28_3 || prev_sym == K28_4)) begin
            fast_k = prev_sym;
            fast_d = sym;
            fcnt++;
            if (prev_sym == K28_3) begin
                case (sym[7:3]) // register chosen by x field
                    5'h01: if (sym[2:0] == 3'h1 && clr_cnt == 0) clr_cnt = 4;
                    5'h02: acq_reg[sym[2:0] - 3'h1] = 1'b1;
                    5'h03: flow_reg[sym[2:0] - 3'h1] = 1'b1;
                    5'h0B: cal_reg[sym[2:0] - 3'h1] = 1'b1;
                    default: ;
                endcase
            end
        end
        if (prev_k && prev_sym == K28_5 && !is_k) begin
            if (first_idle == 8'h00) first_idle = sym;
            if (sym != D5_6 && sym != D16_2) seq_err++;
        end
        if (is_k && sym == K27_7) begin
            in_frame = 1'b1;
            frm.delete();
        end else if (in_frame && !is_k) begin
            frm.push_back(sym);
        end else if (is_k && sym == K29_7) begin
            in_frame = 1'b0;
            frames++;
            pads = 0;
            // frames failing length or check would be dropped
            c = CRC_INIT;
            for (int i = 0; i + 2 < frm.size(); i += 2) begin
                w = {frm[i], frm[i + 1]};
                for (int b = 15; b >= 0; b--)
                    c = (c << 1) ^ ((c[15] ^ w[b]) ? CRC_POLY : 16'h0000);
            end
            if (frm.size() < 12 || frm.size() != 2 * ({frm[8], frm[9]} + 6)
                || c != {frm[frm.size() - 2], frm[frm.size() - 1]}) bad_frames++;
        end else if (is_k && sym == K23_7) begin
            pads++;
        end
        prev_sym = sym;
        prev_k = is_k;
    end
endmodule // dlc_dev_model

// [dv/dlc_link_master_test.sv]
// Purpose: self-checking bench of the link master
// Assumes: device model decodes the link symbols
// Notes: crc reference is computed here, bit by bit
`timescale 1ns/1ns
module dlc_link_master_test
    import dlc_pkg::*;
;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic sw_wr = 1'b0;
    logic sw_rd = 1'b0;
    logic full_req = 1'b0;
    logic [7:0] sw_addr = 8'h00;
    logic [15:0] sw_wdata = 16'h0000;
    logic [15:0] sw_rdata;
    logic [7:0] link_sym;
    logic link_clk_out;
    logic link_is_k;
    logic full_flag;
    logic [15:0] r;
    int err_total = 0;
    int comparisons = 0;

    dlc_link_master DUT (.core_clk(core_clk), .reset(reset), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
        .link_clk_out(link_clk_out), .link_sym(link_sym), .link_is_k(link_is_k),
        .buffer_full_flag(full_flag));
    dlc_dev_model model (.link_clk(link_clk_out), .sym(link_sym), .is_k(link_is_k),
        .full_req(full_req), .full_out(full_flag));

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge core_clk);
        sw_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge core_clk);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask

    function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [15:0] w);
        for (int i = 15; i >= 0; i--)
            c = (c << 1) ^ ((c[15] ^ w[i]) ? CRC_POLY : 16'h0000);
        return c;
    endfunction

    task automatic t_reset_values;
        rd(REG_CTRL, r);
        check(r, 16'h0000);
        rd(REG_PKT_TYPE, r);
        check(r, 16'h0002);
        rd(REG_SEQ, r);
        check(r, 16'h0000);
        rd(8'h20, r);
        check(r, 16'h0000);
        @(posedge core_clk);
        #1 check(sw_rdata, 16'h0000);
    endtask

    // class in bits 9:8, command byte below
    task automatic t_fast;
        logic [9:0] ft[12] = '{10'h109, 10'h111, 10'h112, 10'h113, 10'h119, 10'h11A,
            10'h159, 10'h15A, 10'h15B, 10'h15C, 10'h009, 10'h209};
        logic [7:0] ck[3] = '{K28_0, K28_3, K28_4};
        logic [15:0] ev[12] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0001, 16'h0002,
            16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0000, 16'h0000};
        int n;
        foreach (ft[j]) begin
            n = model.fcnt;
            model.clr_len = 0;
            wr(REG_FAST, {6'h00, ft[j]});
            wr(REG_CTRL, 16'h0001);
            for (int i = 0; i < 200 && model.fcnt == n; i++) @(posedge core_clk);
            check({model.fast_k, model.fast_d}, {ck[ft[j][9:8]], ft[j][7:0]});
            check(model.acq_reg | model.flow_reg | model.cal_reg, ev[j]);
            if (ft[j] == 10'h109) begin
                repeat (12) @(posedge core_clk);
                check(16'(model.clr_len), 16'h0004);
            end
        end
    endtask

    task automatic t_refuse;
        int n;
        n = model.fcnt;
        wr(REG_FAST, 16'h0321);
        wr(REG_CTRL, 16'h0001);
        rd(REG_CTRL, r);
        check(r, 16'h0002);
        wr(REG_FAST, 16'h0121);
        wr(REG_CTRL, 16'h0003);
        rd(REG_CTRL, r);
        check(r, 16'h0002);
        wr(REG_LENGTH, 16'h01FB);
        wr(REG_CTRL, 16'h0002);
        rd(REG_CTRL, r);
        check(r, 16'h0002);
        repeat (20) @(posedge core_clk);
        check(16'(model.fcnt), 16'(n));
        check(16'(model.frames), 16'h0000);
    endtask

    task automatic t_block(input logic [15:0] pt, sel, spec, len);
        logic [15:0] seq;
        logic [15:0] crc;
        logic [15:0] w[$];
        int nf;
        wr(REG_PKT_TYPE, pt);
        wr(REG_SELECTOR, sel);
        wr(REG_SPECIFIER, spec);
        wr(REG_LENGTH, len);
        rd(REG_SEQ, seq);
        w = '{pt, seq, sel, spec, len};
        for (int i = 0; i < len; i++) begin
            w.push_back(16'(i * 3 + 1));
            wr(REG_DATA, w[i + 5]);
        end
        crc = CRC_INIT;
        foreach (w[i]) crc = crc_word(crc, w[i]);
        w.push_back(crc);
        nf = model.frames;
        wr(REG_CTRL, 16'h0002);
        // config change while busy must be dropped
        wr(REG_SELECTOR, ~sel);
        for (int i = 0; i < 4000 && model.frames == nf; i++) @(posedge core_clk);
        check(16'(model.frm.size()), 16'(2 * w.size()));
        foreach (w[i]) check({model.frm[2 * i], model.frm[2 * i + 1]}, w[i]);
        repeat (6) @(posedge core_clk);
        check(16'(model.pads), 16'h0002);
        rd(REG_SELECTOR, r);
        check(r, sel);
        rd(REG_SEQ, r);
        check(r, seq + 16'h0001);
        rd(REG_CTRL, r);
        check(r, 16'h0000);
    endtask

    task automatic t_full;
        full_req <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(REG_CTRL, r);
        check(r, 16'h0004);
        full_req <= 1'b0;
        repeat (4) @(posedge core_clk);
        rd(REG_CTRL, r);
        check(r, 16'h0000);
    endtask

    initial begin
        repeat (3) @(posedge core_clk);
        #1 check({8'h00, link_sym}, {8'h00, K28_5});
        @(posedge core_clk);
        reset <= 1'b0;
        t_reset_values();
        t_fast();
        t_refuse();
        t_block(16'h0012, 16'h0004, 16'h0008, 16'h0002);
        t_block(16'h1081, 16'h000A, 16'h1000, 16'h0000);
        t_block(16'h0101, 16'h0018, 16'h0001, 16'h01FA);
        t_full();
        check(16'(model.seq_err), 16'h0000);
        check({8'h00, model.first_idle}, {8'h00, D5_6});
        check(16'(model.bad_frames), 16'h0000);
        finish_test();
    end

    // whole run is near 3500 cycles
    initial begin
        #400000;
        err_total++;
        finish_test();
    end
endmodule // dlc_link_master_test
